// ### rtl/pcr_params.svh
// Constants of the pad configuration and soft reset register bank.
// Assumes a 16-bit register address and 16-bit register data.
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// ********************************************************************
// Register widths
// ********************************************************************
`define PCR_ADDR_W             16
`define PCR_DATA_W             16

// ********************************************************************
// Register offsets
// ********************************************************************
`define PCR_MASTER_DATA_OUT_OFS 16'hf7a0
`define PCR_MULTIPURPOSE6_OFS   16'hf7a1
`define PCR_MULTIPURPOSE7_OFS   16'hf7a2
`define PCR_CLOCK_OUTPUT_OFS    16'hf7a3
`define PCR_CONTROL_RESET_OFS   16'hf890
`define PCR_CLOCKGEN_FIRST_OFS  16'hf000
`define PCR_CLOCKGEN_LAST_OFS   16'hf006

// ********************************************************************
// Reset values
// ********************************************************************
`define PCR_MASTER_DATA_OUT_RST 16'h0018
`define PCR_MULTIPURPOSE6_RST   16'h0018
`define PCR_MULTIPURPOSE7_RST   16'h0018
`define PCR_CLOCK_OUTPUT_RST    16'h0008
`define PCR_CONTROL_RESET_RST   16'h0001

// ********************************************************************
// Field positions
// ********************************************************************
`define PCR_PULL_BIT           4
`define PCR_SLEW_MSB           3
`define PCR_SLEW_LSB           2
`define PCR_DRIVE_MSB          1
`define PCR_DRIVE_LSB          0
`define PCR_RUN_N_BIT          0

`endif

// ### rtl/pcr_pkg.sv
// Types shared by the pad configuration and soft reset register bank.
// Assumes pcr_params.svh is on the include path.
`default_nettype none
`include "pcr_params.svh"

package pcr_pkg;

	// Slave control port mode; four-wire is left only by hardware reset
	typedef enum logic {
		PCR_MODE_TWO_WIRE,
		PCR_MODE_FOUR_WIRE
	} pcr_mode_t;

	typedef logic [`PCR_DATA_W-1:0] pcr_word_t;
	typedef logic [`PCR_ADDR_W-1:0] pcr_addr_t;

endpackage : pcr_pkg

`default_nettype wire

// ### rtl/pcr_reset_sync.sv
// Two-stage release synchroniser for the active-low hardware reset.
// Assumes the reset input may fall at any time relative to the clock.
`default_nettype none
`include "pcr_params.svh"

module pcr_reset_sync
	import pcr_pkg::*;
(
	input  wire logic ref_clk,     // Bank clock
	input  wire logic rstn,        // Raw hardware reset, active low
	output logic      rst_sync_n   // Released two edges after rstn rises
);

	typedef struct packed {
		logic meta;
		logic sync;
	} pcr_sync_state_t;

	pcr_sync_state_t state;
	pcr_sync_state_t next_state;

	// Shift a one in; the first stage feeds only the second
	always_comb begin
		next_state.meta = 1'b1;
		next_state.sync = state.meta;
	end

	// Asserts at once, releases on the clock
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rst_sync_n = state.sync;

endmodule : pcr_reset_sync

`default_nettype wire

// ### rtl/pcr_pad_reg.sv
// One 16-bit pad configuration register with hardware and soft reset.
// Assumes the caller decodes the address into wr_en.
`default_nettype none
`include "pcr_params.svh"

module pcr_pad_reg
	import pcr_pkg::*;
#(
	parameter pcr_word_t RESET_VALUE = `PCR_MASTER_DATA_OUT_RST
) (
	input  wire logic      ref_clk,      // Bank clock
	input  wire logic      rst_n,        // Synchronised hardware reset
	input  wire logic      soft_rst_act, // Soft reset held, forces default
	input  wire logic      wr_en,        // Write strobe for this register
	input  wire pcr_word_t wr_data,      // Write data
	output pcr_word_t      value         // Stored register value
);

	typedef struct packed {
		pcr_word_t value;
	} pcr_pad_state_t;

	pcr_pad_state_t state;
	pcr_pad_state_t next_state;

	// Soft reset wins over a write so the pad stays at default while held
	always_comb begin
		next_state = state;
		if (soft_rst_act) begin
			next_state.value = RESET_VALUE;
		end else if (wr_en) begin
			next_state.value = wr_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state.value <= RESET_VALUE;
		end else begin
			state <= next_state;
		end
	end

	assign value = state.value;

endmodule : pcr_pad_reg

`default_nettype wire

// ### rtl/pcr_top.sv
// Pad configuration registers and the soft reset control register.
// Assumes a simple synchronous register port from the slave control
// ports, one access per cycle, and pad cells taking static levels.
//
// Notes on behaviour
// - Master data out pad register, 0xf7a0, 0x0018.
// - Multipurpose six pad register, 0xf7a1, 0x0018.
// - Multipurpose seven pad register, 0xf7a2, 0x0018.
// - Clock output pad register, 0xf7a3, 0x0008.
// - Slew bits 3:2, drive bits 1:0.
// - Bit 4 enables pull resistor.
// - Reserved pad bits read and write.
// - Soft reset register at 0xf890, 0x0001.
// - Bit 0 low holds soft reset.
// - Soft reset defaults all but clockgen, panic.
// - Slave ports and clockgen writes keep working.
// - Four-wire mode survives soft reset.
// - Only hardware reset returns to two-wire.
// - Soft reset resembles holding hardware reset.
`default_nettype none
`include "pcr_params.svh"

module pcr_top
	import pcr_pkg::*;
(
	input  wire logic      ref_clk,                   // Bank clock, 250 MHz
	input  wire logic      rstn,                      // Hardware reset pin, active low
	// Register port from the slave control ports
	input  wire pcr_addr_t reg_addr,                  // Register address
	input  wire logic      reg_wr_en,                 // Write strobe, one cycle
	input  wire pcr_word_t reg_wr_data,               // Write data
	input  wire logic      reg_rd_en,                 // Read strobe, one cycle
	output pcr_word_t      reg_rd_data,               // Read data, registered
	output logic           reg_rd_valid,              // Read data valid pulse
	// Slave mode selection
	input  wire logic      four_wire_select,          // Pulse: four-wire protocol seen
	output logic           four_wire_mode,            // Level: four-wire slave mode
	// Reset distribution
	output logic           soft_reset_active,         // Level: soft reset held
	output logic           control_reg_rst_n,         // Reset for ordinary control regs
	output logic           retained_reg_rst_n,        // Reset for clockgen and panic regs
	output logic           clockgen_wr_sel,           // Write hits clockgen range
	// Master data out pin pad
	output logic           master_data_out_pullup_en, // Pull-up enable
	output logic [1:0]     master_data_out_slew_sel,  // Slew code
	output logic [1:0]     master_data_out_drive_sel, // Drive code
	// Multipurpose pin six pad
	output logic           multipurpose6_pulldown_en, // Pull-down enable
	output logic [1:0]     multipurpose6_slew_sel,    // Slew code
	output logic [1:0]     multipurpose6_drive_sel,   // Drive code
	// Multipurpose pin seven pad
	output logic           multipurpose7_pulldown_en, // Pull-down enable
	output logic [1:0]     multipurpose7_slew_sel,    // Slew code
	output logic [1:0]     multipurpose7_drive_sel,   // Drive code
	// Clock output pin pad
	output logic           clock_output_pulldown_en,  // Pull-down enable
	output logic [1:0]     clock_output_slew_sel,     // Slew code
	output logic [1:0]     clock_output_drive_sel     // Drive code
);

	// ****************************************************************
	// Reset release
	// ****************************************************************

	logic rst_n;

	// Every flip-flop below uses the synchronised copy
	pcr_reset_sync u_reset_sync (
		.ref_clk    (ref_clk),
		.rstn       (rstn),
		.rst_sync_n (rst_n)
	);

	// ****************************************************************
	// Bank state
	// ****************************************************************

	typedef struct packed {
		pcr_word_t control_reset_ctrl; // Soft reset register, all bits stored
		pcr_word_t rd_data;            // Captured read data
		logic      rd_valid;           // Read answer pulse
		pcr_mode_t mode;               // Slave control port mode
	} pcr_state_t;

	pcr_state_t state;
	pcr_state_t next_state;

	// ****************************************************************
	// Address decode
	// ****************************************************************

	logic      wr_master_data_out;
	logic      wr_multipurpose6;
	logic      wr_multipurpose7;
	logic      wr_clock_output;
	logic      wr_control_reset;
	logic      soft_act;
	pcr_word_t master_data_out_pad_cfg;
	pcr_word_t multipurpose6_pad_cfg;
	pcr_word_t multipurpose7_pad_cfg;
	pcr_word_t clock_output_pad_cfg;

	// One strobe per register; the port itself never sees soft reset
	assign wr_master_data_out = reg_wr_en && (reg_addr == `PCR_MASTER_DATA_OUT_OFS);
	assign wr_multipurpose6   = reg_wr_en && (reg_addr == `PCR_MULTIPURPOSE6_OFS);
	assign wr_multipurpose7   = reg_wr_en && (reg_addr == `PCR_MULTIPURPOSE7_OFS);
	assign wr_clock_output    = reg_wr_en && (reg_addr == `PCR_CLOCK_OUTPUT_OFS);
	assign wr_control_reset   = reg_wr_en && (reg_addr == `PCR_CONTROL_RESET_OFS);

	// Clockgen writes pass through even while soft reset is held
	assign clockgen_wr_sel = reg_wr_en
		&& (reg_addr >= `PCR_CLOCKGEN_FIRST_OFS)
		&& (reg_addr <= `PCR_CLOCKGEN_LAST_OFS);

	// Active-low run bit; a zero holds the bank in soft reset
	assign soft_act = ~state.control_reset_ctrl[`PCR_RUN_N_BIT];

	// ****************************************************************
	// Pad configuration registers
	// ****************************************************************

	// Pull-up pad; forced to default while soft reset is held
	pcr_pad_reg #(
		.RESET_VALUE (`PCR_MASTER_DATA_OUT_RST)
	) u_master_data_out (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.soft_rst_act (soft_act),
		.wr_en        (wr_master_data_out),
		.wr_data      (reg_wr_data),
		.value        (master_data_out_pad_cfg)
	);

	// Pull-down pad, pull enabled after reset
	pcr_pad_reg #(
		.RESET_VALUE (`PCR_MULTIPURPOSE6_RST)
	) u_multipurpose6 (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.soft_rst_act (soft_act),
		.wr_en        (wr_multipurpose6),
		.wr_data      (reg_wr_data),
		.value        (multipurpose6_pad_cfg)
	);

	// Pull-down pad, pull enabled after reset
	pcr_pad_reg #(
		.RESET_VALUE (`PCR_MULTIPURPOSE7_RST)
	) u_multipurpose7 (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.soft_rst_act (soft_act),
		.wr_en        (wr_multipurpose7),
		.wr_data      (reg_wr_data),
		.value        (multipurpose7_pad_cfg)
	);

	// Pull-down pad, pull disabled after reset so the clock is not loaded
	pcr_pad_reg #(
		.RESET_VALUE (`PCR_CLOCK_OUTPUT_RST)
	) u_clock_output (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.soft_rst_act (soft_act),
		.wr_en        (wr_clock_output),
		.wr_data      (reg_wr_data),
		.value        (clock_output_pad_cfg)
	);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************

	// Soft reset register, read path and slave mode in one place
	always_comb begin
		next_state          = state;
		next_state.rd_valid = reg_rd_en;

		// Soft reset register stays writable so software can leave the state
		if (wr_control_reset) begin
			next_state.control_reset_ctrl = reg_wr_data;
		end

		// Reads keep answering during soft reset; unmapped reads give zero
		if (reg_rd_en) begin
			case (reg_addr)
				`PCR_MASTER_DATA_OUT_OFS: next_state.rd_data = master_data_out_pad_cfg;
				`PCR_MULTIPURPOSE6_OFS:   next_state.rd_data = multipurpose6_pad_cfg;
				`PCR_MULTIPURPOSE7_OFS:   next_state.rd_data = multipurpose7_pad_cfg;
				`PCR_CLOCK_OUTPUT_OFS:    next_state.rd_data = clock_output_pad_cfg;
				`PCR_CONTROL_RESET_OFS:   next_state.rd_data = state.control_reset_ctrl;
				default:                  next_state.rd_data = '0;
			endcase
		end

		// Four-wire mode is sticky; soft reset has no say in it
		case (state.mode)
			PCR_MODE_TWO_WIRE: begin
				if (four_wire_select) begin
					next_state.mode = PCR_MODE_FOUR_WIRE;
				end
			end
			PCR_MODE_FOUR_WIRE: begin
				next_state.mode = PCR_MODE_FOUR_WIRE;
			end
			default: begin
				next_state.mode = PCR_MODE_TWO_WIRE;
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// Only the hardware reset returns the mode to two-wire
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state.control_reset_ctrl <= `PCR_CONTROL_RESET_RST;
			state.rd_data            <= '0;
			state.rd_valid           <= 1'b0;
			state.mode               <= PCR_MODE_TWO_WIRE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Reset distribution
	// ****************************************************************

	// Ordinary control registers see soft reset like the reset pin;
	// clockgen and panic registers see the pin alone and keep contents
	assign soft_reset_active  = soft_act;
	assign control_reg_rst_n  = rst_n & ~soft_act;
	assign retained_reg_rst_n = rst_n;

	// ****************************************************************
	// Register port outputs
	// ****************************************************************

	assign reg_rd_data    = state.rd_data;
	assign reg_rd_valid   = state.rd_valid;
	assign four_wire_mode = (state.mode == PCR_MODE_FOUR_WIRE);

	// ****************************************************************
	// Pad cell levels
	// ****************************************************************

	// Fields go straight from the stored words, so pads never glitch
	assign master_data_out_pullup_en = master_data_out_pad_cfg[`PCR_PULL_BIT];
	assign master_data_out_slew_sel  = master_data_out_pad_cfg[`PCR_SLEW_MSB:`PCR_SLEW_LSB];
	assign master_data_out_drive_sel = master_data_out_pad_cfg[`PCR_DRIVE_MSB:`PCR_DRIVE_LSB];

	assign multipurpose6_pulldown_en = multipurpose6_pad_cfg[`PCR_PULL_BIT];
	assign multipurpose6_slew_sel    = multipurpose6_pad_cfg[`PCR_SLEW_MSB:`PCR_SLEW_LSB];
	assign multipurpose6_drive_sel   = multipurpose6_pad_cfg[`PCR_DRIVE_MSB:`PCR_DRIVE_LSB];

	assign multipurpose7_pulldown_en = multipurpose7_pad_cfg[`PCR_PULL_BIT];
	assign multipurpose7_slew_sel    = multipurpose7_pad_cfg[`PCR_SLEW_MSB:`PCR_SLEW_LSB];
	assign multipurpose7_drive_sel   = multipurpose7_pad_cfg[`PCR_DRIVE_MSB:`PCR_DRIVE_LSB];

	assign clock_output_pulldown_en  = clock_output_pad_cfg[`PCR_PULL_BIT];
	assign clock_output_slew_sel     = clock_output_pad_cfg[`PCR_SLEW_MSB:`PCR_SLEW_LSB];
	assign clock_output_drive_sel    = clock_output_pad_cfg[`PCR_DRIVE_MSB:`PCR_DRIVE_LSB];

endmodule : pcr_top

`default_nettype wire

// ### test/pcr_top_monitor.sv
// Checker for the pad configuration and soft reset register bank.
// Assumes it is bound into pcr_top and sees only its ports.
`default_nettype none
`include "pcr_params.svh"

module pcr_monitor
	import pcr_pkg::*;
(
	input wire logic       ref_clk,                   // Bank clock
	input wire logic       rstn,                      // Hardware reset, active low
	input wire pcr_addr_t  reg_addr,                  // Register address
	input wire logic       reg_wr_en,                 // Write strobe
	input wire pcr_word_t  reg_wr_data,               // Write data
	input wire logic       reg_rd_en,                 // Read strobe
	input wire logic       reg_rd_valid,              // Read data valid
	input wire logic       four_wire_select,          // Four-wire seen
	input wire logic       four_wire_mode,            // Four-wire mode
	input wire logic       soft_reset_active,         // Soft reset held
	input wire logic       control_reg_rst_n,         // Control register reset
	input wire logic       retained_reg_rst_n,        // Retained register reset
	input wire logic       clockgen_wr_sel,           // Clockgen write hit
	input wire logic       master_data_out_pullup_en, // Pad field
	input wire logic [1:0] master_data_out_slew_sel,  // Pad field
	input wire logic [1:0] master_data_out_drive_sel, // Pad field
	input wire logic       multipurpose6_pulldown_en, // Pad field
	input wire logic [1:0] multipurpose6_slew_sel,    // Pad field
	input wire logic [1:0] multipurpose6_drive_sel,   // Pad field
	input wire logic       multipurpose7_pulldown_en, // Pad field
	input wire logic [1:0] multipurpose7_slew_sel,    // Pad field
	input wire logic [1:0] multipurpose7_drive_sel,   // Pad field
	input wire logic       clock_output_pulldown_en,  // Pad field
	input wire logic [1:0] clock_output_slew_sel,     // Pad field
	input wire logic [1:0] clock_output_drive_sel     // Pad field
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********************
	// Helpers
	// ********************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// Pad fields regrouped as pull, slew, drive
	logic [4:0] pad_m, pad_6, pad_7, pad_c;
	assign pad_m = {master_data_out_pullup_en, master_data_out_slew_sel, master_data_out_drive_sel};
	assign pad_6 = {multipurpose6_pulldown_en, multipurpose6_slew_sel, multipurpose6_drive_sel};
	assign pad_7 = {multipurpose7_pulldown_en, multipurpose7_slew_sel, multipurpose7_drive_sel};
	assign pad_c = {clock_output_pulldown_en, clock_output_slew_sel, clock_output_drive_sel};

	// A pad write that must land; soft reset would force the default instead
	sequence pad_wr(logic [15:0] a);
		reg_wr_en && reg_addr == a && !soft_reset_active && retained_reg_rst_n;
	endsequence
	// Pads are forced one edge after soft reset takes hold
	sequence soft_held;
		soft_reset_active ##1 soft_reset_active;
	endsequence

	// ********************
	// Assertions
	// ********************
	mdo_write_a : assert property (
		pad_wr(16'hf7a0) |=> pad_m == $past(reg_wr_data[4:0])) else $error("master pad not updated");
	mp6_write_a : assert property (
		pad_wr(16'hf7a1) |=> pad_6 == $past(reg_wr_data[4:0])) else $error("pad six not updated");
	mp7_write_a : assert property (
		pad_wr(16'hf7a2) |=> pad_7 == $past(reg_wr_data[4:0])) else $error("pad seven not updated");
	clk_write_a : assert property (
		pad_wr(16'hf7a3) |=> pad_c == $past(reg_wr_data[4:0])) else $error("clock pad not updated");
	soft_dflt_a : assert property (
		soft_held |-> {pad_m, pad_6, pad_7, pad_c} == 20'hc6308) else $error("pads not at default");
	soft_entry_a : assert property (
		reg_wr_en && reg_addr == 16'hf890 && retained_reg_rst_n |=> soft_reset_active == !$past(reg_wr_data[0]))
		else $error("soft reset state wrong");
	rst_split_a : assert property (
		control_reg_rst_n == (retained_reg_rst_n && !soft_reset_active)) else $error("reset split wrong");
	rst_release_a : assert property (
		$rose(rstn) |-> !retained_reg_rst_n ##1 !retained_reg_rst_n ##1 retained_reg_rst_n)
		else $error("reset release timing wrong");
	fw_set_a : assert property (
		four_wire_select && retained_reg_rst_n |=> four_wire_mode) else $error("four-wire not entered");
	fw_hold_a : assert property (
		four_wire_mode |=> four_wire_mode) else $error("four-wire mode left");
	rd_pulse_a : assert property (
		reg_rd_valid == $past(reg_rd_en)) else $error("read valid timing wrong");
	cg_decode_a : assert property (
		clockgen_wr_sel == (reg_wr_en && reg_addr >= 16'hf000 && reg_addr <= 16'hf006))
		else $error("clockgen decode wrong");
endmodule : pcr_monitor

bind pcr_top pcr_monitor u_mon (
	.ref_clk, .rstn, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_valid,
	.four_wire_select, .four_wire_mode, .soft_reset_active, .control_reg_rst_n,
	.retained_reg_rst_n, .clockgen_wr_sel,
	.master_data_out_pullup_en, .master_data_out_slew_sel, .master_data_out_drive_sel,
	.multipurpose6_pulldown_en, .multipurpose6_slew_sel, .multipurpose6_drive_sel,
	.multipurpose7_pulldown_en, .multipurpose7_slew_sel, .multipurpose7_drive_sel,
	.clock_output_pulldown_en, .clock_output_slew_sel, .clock_output_drive_sel
);

`default_nettype wire

// ### test/pcr_top_tb.sv
// Self-checking bench for the pad configuration and soft reset bank.
// Assumes pcr_pkg and pcr_params.svh are compiled and on the path.
`default_nettype none
`include "pcr_params.svh"

module pcr_top_tb
	import pcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ********************
	// Signals and tables
	// ********************
	logic       ref_clk, rstn, reg_wr_en, reg_rd_en, reg_rd_valid, four_wire_select, four_wire_mode;
	logic       soft_reset_active, control_reg_rst_n, retained_reg_rst_n, clockgen_wr_sel, cg_seen;
	logic       master_data_out_pullup_en, multipurpose6_pulldown_en;
	logic       multipurpose7_pulldown_en, clock_output_pulldown_en;
	logic [1:0] master_data_out_slew_sel, master_data_out_drive_sel, multipurpose6_slew_sel;
	logic [1:0] multipurpose6_drive_sel, multipurpose7_slew_sel, multipurpose7_drive_sel;
	logic [1:0] clock_output_slew_sel, clock_output_drive_sel;
	pcr_addr_t  reg_addr;
	pcr_word_t  reg_wr_data, reg_rd_data, rd_word;
	pcr_word_t  mdl [4];
	logic [31:0] seed;
	int         error_cnt, total_checks, k;
	wire logic [19:0] pads_seen;

	localparam pcr_addr_t ADDR [5] = '{`PCR_MASTER_DATA_OUT_OFS, `PCR_MULTIPURPOSE6_OFS,
		`PCR_MULTIPURPOSE7_OFS, `PCR_CLOCK_OUTPUT_OFS, `PCR_CONTROL_RESET_OFS};
	localparam pcr_word_t DFLT [5] = '{16'h0018, 16'h0018, 16'h0018, 16'h0008, 16'h0001};

	assign pads_seen = {master_data_out_pullup_en, master_data_out_slew_sel, master_data_out_drive_sel,
		multipurpose6_pulldown_en, multipurpose6_slew_sel, multipurpose6_drive_sel,
		multipurpose7_pulldown_en, multipurpose7_slew_sel, multipurpose7_drive_sel,
		clock_output_pulldown_en, clock_output_slew_sel, clock_output_drive_sel};

	pcr_top dut (
		.ref_clk, .rstn, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid,
		.four_wire_select, .four_wire_mode, .soft_reset_active, .control_reg_rst_n,
		.retained_reg_rst_n, .clockgen_wr_sel,
		.master_data_out_pullup_en, .master_data_out_slew_sel, .master_data_out_drive_sel,
		.multipurpose6_pulldown_en, .multipurpose6_slew_sel, .multipurpose6_drive_sel,
		.multipurpose7_pulldown_en, .multipurpose7_slew_sel, .multipurpose7_drive_sel,
		.clock_output_pulldown_en, .clock_output_slew_sel, .clock_output_drive_sel
	);

	// ********************
	// Helpers
	// ********************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr_next

	// Pad levels implied by the model of the four pad registers
	function automatic logic [19:0] pad_exp();
		return {mdl[0][4:0], mdl[1][4:0], mdl[2][4:0], mdl[3][4:0]};
	endfunction : pad_exp

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// The wr, chk_reg and hw_reset tasks start at a rising edge and end at a falling edge, where outputs are settled
	task automatic wr(input pcr_addr_t a, input pcr_word_t d);
		@(posedge ref_clk);
		reg_addr    <= a;
		reg_wr_data <= d;
		reg_wr_en   <= 1'b1;
		@(negedge ref_clk);
		cg_seen = clockgen_wr_sel;
		@(posedge ref_clk);
		reg_wr_en <= 1'b0;
		@(negedge ref_clk);
	endtask : wr

	task automatic chk_reg(input pcr_addr_t a, input pcr_word_t e);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		@(posedge ref_clk);
		reg_rd_en <= 1'b0;
		@(negedge ref_clk);
		chk("read valid", reg_rd_valid, 1'b1);
		chk("read data", reg_rd_data, e);
	endtask : chk_reg

	// Hold the pin low for six cycles, then leave room for the release stages
	task automatic hw_reset();
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		for (int i = 0; i < 4; i++) mdl[i] = DFLT[i];
	endtask : hw_reset

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// ********************
	// Clock, watchdog, tests
	// ********************
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Whole run is well under a thousand cycles; a hang trips this
	initial begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		report_and_stop();
	end

	initial begin
		rstn = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		four_wire_select = 1'b0;
		reg_addr = '0;
		reg_wr_data = '0;
		seed = 32'hde9eacfd;
		hw_reset();
		for (int i = 0; i < 5; i++) chk_reg(ADDR[i], DFLT[i]);
		chk("pads", pads_seen, pad_exp());
		chk_reg(16'hf7a4, 16'h0000);
		wr(ADDR[2], 16'hffff);
		mdl[2] = 16'hffff;
		chk_reg(ADDR[2], 16'hffff);
		// Every slew and drive code on one pad, then random words with reserved bits kept zero
		for (int c = 0; c < 4; c++) begin
			mdl[1] = {11'h0, c[0], c[1:0], c[1:0]};
			wr(ADDR[1], mdl[1]);
			chk("pads", pads_seen, pad_exp());
		end
		for (int n = 0; n < 24; n++) begin
			seed = lfsr_next(seed);
			k = int'(seed[17:16]);
			mdl[k] = {11'h0, seed[4:0]};
			wr(ADDR[k], mdl[k]);
			chk("pads", pads_seen, pad_exp());
			chk_reg(ADDR[k], mdl[k]);
		end
		// Four-wire mode first, then soft reset with pads, clockgen and reads exercised
		@(posedge ref_clk);
		four_wire_select <= 1'b1;
		@(posedge ref_clk);
		four_wire_select <= 1'b0;
		wr(`PCR_CONTROL_RESET_OFS, 16'h0000);
		for (int i = 0; i < 4; i++) mdl[i] = DFLT[i];
		chk("soft active", soft_reset_active, 1'b1);
		chk("control rst", control_reg_rst_n, 1'b0);
		chk("retained rst", retained_reg_rst_n, 1'b1);
		chk("four wire", four_wire_mode, 1'b1);
		// Pads are forced on the edge after the run bit clears, so let one edge pass
		@(negedge ref_clk);
		chk("pads", pads_seen, pad_exp());
		wr(ADDR[0], 16'h0007);
		chk_reg(ADDR[0], DFLT[0]);
		wr(16'hf000, 16'h1234);
		chk("clockgen sel", cg_seen, 1'b1);
		wr(16'hf007, 16'h1234);
		chk("clockgen sel", cg_seen, 1'b0);
		chk_reg(`PCR_CONTROL_RESET_OFS, 16'h0000);
		wr(`PCR_CONTROL_RESET_OFS, 16'h0001);
		chk("soft active", soft_reset_active, 1'b0);
		chk("control rst", control_reg_rst_n, 1'b1);
		chk("four wire", four_wire_mode, 1'b1);
		chk("pads", pads_seen, pad_exp());
		mdl[3] = 16'h001f;
		wr(ADDR[3], mdl[3]);
		chk("pads", pads_seen, pad_exp());
		hw_reset();
		chk("four wire", four_wire_mode, 1'b0);
		chk("pads", pads_seen, pad_exp());
		report_and_stop();
	end
endmodule : pcr_top_tb

`default_nettype wire
